/* rtl/dfm_defs.vh */
// Constants for the dual channel frequency meter
`ifndef DFM_DEFS_VH
`define DFM_DEFS_VH
`define DFM_CLK_HZ 50000000
`define DFM_SAMPLE_US 1000
`define DFM_SAMPLE_CYC (`DFM_CLK_HZ / 1000000 * `DFM_SAMPLE_US)
`define DFM_WAIT_MS 1000
`define DFM_WAIT_CYC (`DFM_CLK_HZ / 1000 * `DFM_WAIT_MS)
`define DFM_MODE_A_ONLY 3'h0
`define DFM_MODE_RATIO 3'h1
`define DFM_MODE_PERCENT 3'h2
`define DFM_MODE_SUM 3'h3
`define DFM_MODE_DIFF 3'h4
`define DFM_MODE_QUAD 3'h5
`define DFM_RATIO_SCALE 64'h2710
`define DFM_PCT_SCALE 64'h2710
`define DFM_EXP_FIRST 5'h05
`define DFM_EXP_LAST 5'h10
`define DFM_MAX_BASE 32'h3fffffff
`define DFM_FAULT_A_BIT 9
`define DFM_FAULT_B_BIT 10
`endif

/* rtl/dfm_meter.v */
// Dual channel frequency meter with per-channel smoothing and clamp
`timescale 1ns/1ns
`include "dfm_defs.vh"
module dfm_meter #(
    parameter SAMPLE_CYC = `DFM_SAMPLE_CYC,
    parameter WAIT_A_CYC = `DFM_WAIT_CYC,
    parameter WAIT_B_CYC = `DFM_WAIT_CYC
) (
    input wire clock,
    input wire reset,
    input wire pin_a,
    input wire pin_b,
    input wire [2:0] mode_select,
    input wire [1:0] resolution_select,
    input wire [4:0] smooth_a,
    input wire [4:0] smooth_b,
    output reg [31:0] freq_a,
    output reg [31:0] freq_b,
    output reg [31:0] link_result,
    output reg [15:0] fault_word,
    output reg sample_valid
);
    // Three-stage synchronisers; change counts when stages 2 and 3 agree
    reg [2:0] sa_q;
    reg [2:0] sb_q;
    reg a_st_q;
    reg b_st_q;
    wire [1:0] rise;
    wire dir_rev;
    reg [31:0] tick_q;
    wire tick;
    always @(posedge clock)
    begin
        if (reset)
        begin
            sa_q <= 3'h0;
            sb_q <= 3'h0;
            a_st_q <= 1'b0;
            b_st_q <= 1'b0;
        end
        else
        begin
            sa_q <= {sa_q[1:0], pin_a};
            sb_q <= {sb_q[1:0], pin_b};
            if (sa_q[1] == sa_q[2])
                a_st_q <= sa_q[2];
            if (sb_q[1] == sb_q[2])
                b_st_q <= sb_q[2];
        end
    end
    assign rise[0] = (sa_q[1] == sa_q[2]) && sa_q[2] && !a_st_q;
    assign rise[1] = (sb_q[1] == sb_q[2]) && sb_q[2] && !b_st_q;
    // Direction is latched at A's rise; B's level at a tick means nothing
    reg dir_q;
    always @(posedge clock)
    begin
        if (reset)
            dir_q <= 1'b0;
        else if (rise[0])
            dir_q <= b_st_q;
    end
    // Reverse when B is high at the rising edge of A
    assign dir_rev = dir_q;

    // Sampling interval divider
    always @(posedge clock)
    begin
        if (reset || tick)
            tick_q <= 32'h0;
        else
            tick_q <= tick_q + 32'h1;
    end
    assign tick = (tick_q == SAMPLE_CYC - 1);

    // Per-channel period measurement, resolution scaling and smoothing
    localparam [63:0] CLK_HZ = `DFM_CLK_HZ;
    wire [31:0] filt [0:1];
    wire [1:0] clamp;
    genvar c;
    generate
        for (c = 0; c < 2; c = c + 1)
        begin : g_ch
            reg [31:0] per_cnt_q;
            reg [31:0] per_q;
            reg valid_q;
            reg [31:0] hist_q [0:15];
            reg [47:0] exp_q;
            reg [31:0] res_mul;
            reg [31:0] raw;
            reg [31:0] maxf;
            reg [63:0] num;
            reg [63:0] quo;
            reg [35:0] acc;
            reg [31:0] avg;
            reg [4:0] sm;
            reg [3:0] sh;
            reg [4:0] navg;
            integer i;
            integer j;
            wire [31:0] wait_cyc;
            assign wait_cyc = (c == 0) ? WAIT_A_CYC : WAIT_B_CYC;
            always @*
            begin
                sm = (c == 0) ? smooth_a : smooth_b;
                case (resolution_select)
                    2'h0: res_mul = 32'd1;
                    2'h1: res_mul = 32'd10;
                    2'h2: res_mul = 32'd100;
                    default: res_mul = 32'd1000;
                endcase
                num = CLK_HZ * {32'h0, res_mul};
                // valid_q is only set for a period of at least one cycle
                quo = valid_q ? num / {32'h0, per_q} : 64'h0;
                raw = (quo[63:32] != 32'h0) ? 32'hffffffff : quo[31:0];
                sh = (sm >= `DFM_EXP_FIRST) ? sm[3:0] - 4'h4 : 4'h0;
                // Limit in counts is the same at every resolution
                maxf = `DFM_MAX_BASE >> (sh - 4'h1);
                navg = 5'h1 << sm[2:0];
                acc = 36'h0;
                for (j = 0; j < 16; j = j + 1)
                    if (j < navg)
                        acc = acc + {4'h0, hist_q[j]};
                acc = acc >> sm[2:0];
                avg = acc[31:0];
            end
            // Event-triggered period; timeout forces zero
            always @(posedge clock)
            begin
                if (reset)
                begin
                    per_cnt_q <= 32'h0;
                    per_q <= 32'h0;
                    valid_q <= 1'b0;
                end
                else if (rise[c])
                begin
                    per_cnt_q <= 32'h1;
                    per_q <= per_cnt_q;
                    valid_q <= (per_cnt_q != 32'h0) && 
                        (per_cnt_q <= wait_cyc);
                end
                else if (per_cnt_q != 32'h0)
                begin
                    if (per_cnt_q > wait_cyc)
                    begin
                        valid_q <= 1'b0;
                        per_cnt_q <= 32'h0;
                    end
                    else
                        per_cnt_q <= per_cnt_q + 32'h1;
                end
            end
            // Moving average keeps a 16 deep history; exp uses shift
            always @(posedge clock)
            begin
                if (reset)
                begin
                    exp_q <= 48'h0;
                    for (i = 0; i < 16; i = i + 1)
                        hist_q[i] <= 32'h0;
                end
                else if (tick)
                begin
                    for (i = 1; i < 16; i = i + 1)
                        hist_q[i] <= hist_q[i-1];
                    // History is kept in every mode so a new window is full
                    hist_q[0] <= raw;
                    if (sm >= `DFM_EXP_FIRST && sm <= `DFM_EXP_LAST)
                        exp_q <= exp_q - (exp_q >> sh) +
                            {16'h0, (raw > maxf) ? maxf : raw};
                    else
                        exp_q <= 48'h0;
                end
            end
            assign clamp[c] = (sm >= `DFM_EXP_FIRST) &&
                (sm <= `DFM_EXP_LAST) && (raw > maxf);
            // Exp state holds value scaled by 2^sh to keep precision
            assign filt[c] = (sm == 5'h0) ? raw :
                (sm <= 5'h4) ? avg : exp_q[sh +: 32];
        end
    endgenerate

    // Combined result
    reg [63:0] prod;
    reg signed [63:0] sdev;
    reg signed [63:0] squo;
    reg [31:0] link_d;
    always @*
    begin
        prod = 64'h0;
        sdev = 64'h0;
        squo = 64'h0;
        case (mode_select)
            `DFM_MODE_A_ONLY: link_d = filt[0];
            `DFM_MODE_RATIO:
            begin
                // A zero divisor leaves the result at zero
                if (filt[0] != 32'h0)
                    prod = ({32'h0, filt[1]} * `DFM_RATIO_SCALE)
                        / {32'h0, filt[0]};
                link_d = prod[31:0];
            end
            `DFM_MODE_PERCENT:
            begin
                sdev = $signed({32'h0, filt[1]}) - $signed({32'h0, filt[0]});
                if (filt[0] != 32'h0)
                    squo = (sdev * $signed(`DFM_PCT_SCALE))
                        / $signed({32'h0, filt[0]});
                link_d = squo[31:0];
            end
            `DFM_MODE_SUM: link_d = filt[0] + filt[1];
            `DFM_MODE_DIFF: link_d = filt[0] - filt[1];
            `DFM_MODE_QUAD: link_d = dir_rev ? -filt[0] : filt[0];
            default: link_d = 32'h0;
        endcase
    end
    always @(posedge clock)
    begin
        if (reset)
        begin
            freq_a <= 32'h0;
            freq_b <= 32'h0;
            link_result <= 32'h0;
            fault_word <= 16'h0;
            sample_valid <= 1'b0;
        end
        else
        begin
            sample_valid <= tick;
            if (tick)
            begin
                freq_a <= filt[0];
                freq_b <= (mode_select == `DFM_MODE_A_ONLY) ? 32'h0
                    : filt[1];
                link_result <= link_d;
                fault_word[`DFM_FAULT_A_BIT] <= clamp[0];
                fault_word[`DFM_FAULT_B_BIT] <= clamp[1];
            end
        end
    end
endmodule

/* test/dfm_meter_monitor.sv */
// Port checker for the frequency meter
`timescale 1ns/1ns
module dfm_meter_monitor #(
    parameter SAMPLE_CYC = 100
) (
    input wire clock,
    input wire reset,
    input wire [2:0] mode_select,
    input wire [4:0] smooth_a,
    input wire [4:0] smooth_b,
    input wire [31:0] freq_a,
    input wire [31:0] freq_b,
    input wire [31:0] link_result,
    input wire [15:0] fault_word,
    input wire sample_valid
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    reg [31:0] gap_q;
    reg seen_q;
    wire sv = sample_valid;
    wire calm = smooth_a == 5'h00 && smooth_b == 5'h00;
    always @(posedge clock)
    begin
        gap_q <= (reset || sv) ? 32'h0 : gap_q + 32'h1;
        seen_q <= !reset && (seen_q || sv);
    end
    property p_pulse; sv |=> !sv; endproperty
    a_pulse: assert property (p_pulse) else $error("pulse long");
    property p_period; sv && seen_q |-> gap_q == SAMPLE_CYC - 1; endproperty
    a_period: assert property (p_period) else $error("tick gap");
    property p_hold;
        !sv |-> $stable(freq_a) && $stable(freq_b) && $stable(link_result);
    endproperty
    a_hold: assert property (p_hold) else $error("output moved");
    property p_b_idle;
        sv && mode_select == 3'h0 && $stable(mode_select) |-> freq_b == 0;
    endproperty
    a_b_idle: assert property (p_b_idle) else $error("B active");
    property p_sum; sv && mode_select == 3'h3 && $stable(mode_select) && calm
        |-> link_result == freq_a + freq_b; endproperty
    a_sum: assert property (p_sum) else $error("sum wrong");
    property p_diff; sv && mode_select == 3'h4 && $stable(mode_select) && calm
        |-> link_result == freq_a - freq_b; endproperty
    a_diff: assert property (p_diff) else $error("diff wrong");
    property p_rsvd; fault_word[8:0] == 0 && fault_word[15:11] == 0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("stray fault");
    property p_fault_a; sv && $stable(smooth_a) && smooth_a < 5'h05
        |-> !fault_word[9]; endproperty
    a_fault_a: assert property (p_fault_a) else $error("A clamp");
    c_quad: cover property (sv && mode_select == 3'h5);
    c_clamp: cover property (fault_word[9]);
    c_zero: cover property (sv && freq_a == 0);
endmodule
bind dfm_meter dfm_meter_monitor #(.SAMPLE_CYC(SAMPLE_CYC)) dfm_meter_monitor_i
    (.clock(clock), .reset(reset), .mode_select(mode_select),
    .smooth_a(smooth_a), .smooth_b(smooth_b), .freq_a(freq_a),
    .freq_b(freq_b), .link_result(link_result), .fault_word(fault_word),
    .sample_valid(sample_valid));

/* test/dfm_source.sv */
// Pulse source model for the two meter inputs
`timescale 1ns/1ns
module dfm_source (
    input wire clock,
    input wire [15:0] per_a,
    input wire [15:0] per_b,
    input wire quad,
    input wire rev,
    output wire pin_a,
    output wire pin_b
);
    reg [15:0] cnt_a_q = 16'h0000;
    reg [15:0] cnt_b_q = 16'h0000;
    wire [15:0] sh_a = cnt_a_q + (rev ? per_a / 4 : per_a * 3 / 4);
    always @(posedge clock)
    begin
        cnt_a_q <= (cnt_a_q + 16'h1 >= per_a) ? 16'h0 : cnt_a_q + 16'h1;
        cnt_b_q <= (cnt_b_q + 16'h1 >= per_b) ? 16'h0 : cnt_b_q + 16'h1;
    end
    // A stopped channel rests low, like a dead sensor line
    assign pin_a = per_a != 0 && cnt_a_q < per_a / 2;
    // Forward: B lags A a quarter period, so B is low at A's rise
    assign pin_b = quad ? per_a != 0 && sh_a % per_a < per_a / 2
        : per_b != 0 && cnt_b_q < per_b / 2;
endmodule

/* test/dfm_meter_test.sv */
// Self-checking bench for the frequency meter
`timescale 1ns/1ns
module dfm_meter_test;
    reg clock = 0, reset = 1, quad = 0, rev = 0;
    reg [2:0] mode_select = 3'h0;
    reg [1:0] resolution_select = 2'h0;
    reg [4:0] smooth_a = 5'h00, smooth_b = 5'h00;
    reg [15:0] per_a = 16'h3e8, per_b = 16'h1f4;
    reg [31:0] exp_v;
    wire pin_a, pin_b, sample_valid;
    wire [31:0] freq_a, freq_b, link_result;
    wire [15:0] fault_word;
    integer fail_count = 0, n_checks = 0, i;
    dfm_meter #(.SAMPLE_CYC(100), .WAIT_A_CYC(2000), .WAIT_B_CYC(2000))
        dfm_meter_i (.clock(clock), .reset(reset), .pin_a(pin_a),
        .pin_b(pin_b), .mode_select(mode_select),
        .resolution_select(resolution_select), .smooth_a(smooth_a),
        .smooth_b(smooth_b), .freq_a(freq_a), .freq_b(freq_b),
        .link_result(link_result), .fault_word(fault_word),
        .sample_valid(sample_valid));
    dfm_source dfm_source_i (.clock(clock), .per_a(per_a), .per_b(per_b),
        .quad(quad), .rev(rev), .pin_a(pin_a), .pin_b(pin_b));
    initial forever #10 clock = ~clock;
    task check(input [63:0] name, input [31:0] seen, input [31:0] want);
    begin
        n_checks = n_checks + 1;
        if (seen !== want)
        begin
            fail_count = fail_count + 1;
            $display("[ERR] %0s exp %h seen %h", name, want, seen);
        end
    end
    endtask
    // Thirty ticks cover the input sync, a full period and the timeout
    task run(input [2:0] m, input [1:0] r, input [4:0] sa, input [4:0] sb);
    begin
        mode_select = m;
        resolution_select = r;
        smooth_a = sa;
        smooth_b = sb;
        repeat (30) @(posedge sample_valid);
        @(negedge clock);
    end
    endtask
    task finish_test;
    begin
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask
    initial
    begin
        repeat (100000) @(posedge clock);
        fail_count = fail_count + 1;
        finish_test;
    end
    initial
    begin
        repeat (20) @(negedge clock);
        reset = 0;
        run(3'h0, 2'h0, 5'h00, 5'h00);
        check("link", link_result, 32'hc350);
        check("freq_b", freq_b, 32'h0);
        run(3'h1, 2'h0, 5'h00, 5'h00);
        check("link", link_result, 32'h4e20);
        run(3'h2, 2'h0, 5'h00, 5'h00);
        check("link", link_result, 32'h2710);
        run(3'h3, 2'h0, 5'h00, 5'h00);
        check("link", link_result, 32'h249f0);
        run(3'h4, 2'h0, 5'h00, 5'h00);
        check("link", link_result, 32'hffff3cb0);
        quad = 1;
        run(3'h5, 2'h0, 5'h00, 5'h00);
        check("link", link_result, 32'hc350);
        rev = 1;
        run(3'h5, 2'h0, 5'h00, 5'h00);
        check("link", link_result, 32'hffff3cb0);
        quad = 0;
        exp_v = 32'hc350;
        for (i = 1; i < 4; i = i + 1)
        begin
            run(3'h0, i[1:0], 5'h00, 5'h00);
            exp_v = exp_v * 10;
            check("link", link_result, exp_v);
        end
        run(3'h3, 2'h0, 5'h04, 5'h03);
        check("freq_a", freq_a, 32'hc350);
        check("freq_b", freq_b, 32'h186a0);
        run(3'h0, 2'h3, 5'h10, 5'h00);
        check("fault", {16'h0, fault_word}, 32'h200);
        run(3'h3, 2'h3, 5'h10, 5'h10);
        check("fault", {16'h0, fault_word}, 32'h600);
        run(3'h0, 2'h1, 5'h10, 5'h00);
        check("fault", {16'h0, fault_word}, 32'h0);
        per_a = 16'h0;
        run(3'h3, 2'h0, 5'h00, 5'h00);
        check("freq_a", freq_a, 32'h0);
        check("freq_b", freq_b, 32'h186a0);
        run(3'h1, 2'h0, 5'h00, 5'h00);
        check("link", link_result, 32'h0);
        per_b = 16'h0;
        run(3'h3, 2'h0, 5'h00, 5'h00);
        check("freq_b", freq_b, 32'h0);
        finish_test;
    end
endmodule
